// *** core/hes_params.svh ***
// constants for the highband envelope shaper: sizes, fixed-point figures
// assumes log values in signed Q10.8 (18 bits) and gains in Q12
`ifndef HES_PARAMS_SVH
`define HES_PARAMS_SVH

`define HES_RATE_KHZ   32
`define HES_SUBFR_US   1250
`define HES_SUBFR_LEN  ((`HES_RATE_KHZ * `HES_SUBFR_US) / 1000)
`define HES_NSUB       16
`define HES_FRAME_LEN  (`HES_NSUB * `HES_SUBFR_LEN)
`define HES_Q_ONE      18'h01000
`define HES_G_CAP      18'h03000
`define HES_G_MAX      18'h3ffff
`define HES_LG_ZERO    18'h3c000
`define HES_LG_MIN_INV 18'h3ec12
`define HES_LG_TENTH   18'h3fcae
`define HES_LG_HALF    18'h3ff00
`define HES_LG_16      18'h00400
`define HES_LG_Q12     18'h00c00
`define HES_SM_SCALE   17'h01313
`define HES_DIV3       17'h05556
`define HES_SC0        9'h02b
`define HES_SC1        9'h02b
`define HES_SC2        9'h02b
`define HES_SC3        9'h02b
`define HES_SC4        9'h02b
`define HES_SC5        9'h02b

`endif

// *** core/hes_pkg.sv ***
// types shared by the envelope shaper and its output buffer
// assumes nothing of its surroundings
`default_nettype none
package hes_pkg;
  typedef logic signed [17:0] lg_t;
  typedef logic [51:0] lin_t;
  typedef logic [17:0] gain_t;
  typedef logic signed [15:0] smp_t;
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_ENV  = 2'b01,
    ST_GAIN = 2'b10,
    ST_OUT  = 2'b11
  } state_t;
  typedef struct packed {
    logic [1:0] level;
    logic       flat;
  } mode_t;
endpackage
`default_nettype wire

// *** core/hes_stream_if.sv ***
// sample stream between the shaper core and its output buffer
// assumes both ends share one clock
`default_nettype none
interface hes_stream_if;
  logic          valid;
  logic          ready;
  hes_pkg::smp_t data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// *** core/skid_buf2.sv ***
// two-entry buffer on the output sample path
// assumes the source holds data while valid and not ready
`include "hes_params.svh"
`default_nettype none
module skid_buf2
  import hes_pkg::*;
(
  input  wire logic     i_clk_sys,
  input  wire logic     i_rst_n,
  input  wire logic     i_ce,
  hes_stream_if.snk     s_in,
  output logic          o_valid,
  output smp_t          o_data,
  input  wire logic     i_ready
);
  logic [1:0] cnt_ff;
  logic [1:0] nxt_cnt;
  smp_t       d0_ff;
  smp_t       d1_ff;
  smp_t       nxt_d0;
  smp_t       nxt_d1;
  logic       push;
  logic       pop;

  // ready and valid fall with the clock enable so nothing is taken twice
  assign s_in.ready = i_ce & (cnt_ff != 2'h2);
  assign o_valid    = i_ce & (cnt_ff != 2'h0);
  assign o_data     = d0_ff;
  assign push       = s_in.valid & s_in.ready;
  assign pop        = o_valid & i_ready;

  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_d0  = d0_ff;
    nxt_d1  = d1_ff;
    if (push && !pop)
    begin
      nxt_cnt = cnt_ff + 2'h1;
      if (cnt_ff == 2'h0)
        nxt_d0 = s_in.data;
      else
        nxt_d1 = s_in.data;
    end
    else if (pop && !push)
    begin
      nxt_cnt = cnt_ff - 2'h1;
      nxt_d0  = d1_ff;
    end
    else if (pop && push)
    begin
      nxt_d0 = (cnt_ff == 2'h1) ? s_in.data : d1_ff;
      nxt_d1 = s_in.data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_ff <= 2'h0;
      d0_ff  <= 16'h0000;
      d1_ff  <= 16'h0000;
    end
    else if (i_ce)
    begin
      cnt_ff <= nxt_cnt;
      d0_ff  <= nxt_d0;
      d1_ff  <= nxt_d1;
    end
  end

  a_buf_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_valid && !i_ready |=> o_data == $past(o_data))
    else $error("buffered sample changed while stalled");
  a_buf_full: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    cnt_ff == 2'h2 |-> !s_in.ready)
    else $error("buffer took a word while full");
endmodule
`default_nettype wire

// *** core/highband_envelope_shaper.sv ***
// highband envelope shaper: one frame of samples plus low-band qmf in,
// shaped, flattened or unchanged samples out through a two-entry buffer
// assumes upstream logic on i_clk_sys; log math is piecewise-linear base 2
`include "hes_params.svh"
`default_nettype none
module highband_envelope_shaper
  import hes_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        i_ce,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_hb_valid,
  input  wire logic [15:0] i_hb_data,
  output logic             o_hb_ready,
  input  wire logic        i_qmf_valid,
  input  wire logic [15:0] i_qmf_re,
  input  wire logic [15:0] i_qmf_im,
  input  wire logic        i_qmf_band_end,
  output logic             o_qmf_ready,
  output logic             o_out_valid,
  output logic [15:0]      o_out_data,
  input  wire logic        i_out_ready,
  output logic             o_busy,
  output logic [1:0]       o_shape_level,
  output logic             o_flat
);
  localparam logic [9:0] LAST_ADDR = 10'(`HES_FRAME_LEN - 1);
  localparam logic [5:0] LAST_POS  = 6'(`HES_SUBFR_LEN - 1);
  localparam logic [8:0] SC [6] = '{`HES_SC0, `HES_SC1, `HES_SC2,
                                    `HES_SC3, `HES_SC4, `HES_SC5};

  function automatic lg_t log2q(input lin_t v);
    int   p;
    lin_t n;
    p = 0;
    for (int b = 0; b < 52; b++)
      if (v[b])
        p = b;
    n = v << (51 - p);
    if (v == '0)
      return `HES_LG_ZERO;
    return lg_t'(p * 256) + lg_t'({10'h000, n[50:43]});
  endfunction

  // 2^x scaled by 2^12, saturating
  function automatic lin_t exp2q(input lg_t x);
    int   e;
    lin_t m;
    e = int'(x >>> 8) + 12;
    m = lin_t'({1'b1, x[7:0]});
    if (e > 43)
      return '1;
    if (e >= 8)
      return m << (e - 8);
    return m >> (8 - e);
  endfunction

  function automatic mode_t decode(input logic [1:0] cw);
    unique case (cw)
      2'h0: return '{level: 2'h0, flat: 1'b0};
      2'h1: return '{level: 2'h0, flat: 1'b1};
      2'h2: return '{level: 2'h1, flat: 1'b0};
      2'h3: return '{level: 2'h2, flat: 1'b0};
    endcase
  endfunction

  function automatic logic [10:0] step(input logic [4:0] s, input logic [5:0] p);
    if (p == LAST_POS)
      return {s + 5'h01, 6'h00};
    return {s, p + 6'h01};
  endfunction

  hes_stream_if src ();

  state_t      state_ff, nxt_state;
  logic [4:0]  sub_ff, nxt_sub, slot_ff, nxt_slot;
  logic [5:0]  pos_ff, nxt_pos;
  logic [9:0]  addr_ff, nxt_addr;
  logic [1:0]  band_ff, nxt_band;
  logic [39:0] bacc_ff, nxt_bacc;
  logic [7:0]  bcnt_ff, nxt_bcnt;
  lg_t         sacc_ff, nxt_sacc, inv_ff, nxt_inv;
  mode_t       mode_ff, nxt_mode;
  lin_t        tot_ff, nxt_tot, esum_ff, nxt_esum;
  logic        mem_we, enr_we, env_we, h_we, g_we;

  smp_t        mem [`HES_FRAME_LEN];
  logic [39:0] enr [`HES_NSUB];
  lg_t         env_l [`HES_NSUB];
  lg_t         lg_h [`HES_NSUB];
  lg_t         lg_e [`HES_NSUB];
  gain_t       gain [`HES_NSUB];

  logic               hb_take, qmf_take, hb_done;
  logic [31:0]        sq;
  logic [39:0]        band_sum;
  lg_t                slot_lg, env_new, lg_tot, lg_hn, lg_en, cand;
  lg_t                lg_mean, lg_floor, lg_lim, lg_flat;
  logic signed [34:0] div3_p, out_p;
  logic signed [31:0] sm_acc;
  logic signed [33:0] sm_p;
  lin_t               shp_lin, flt_lin;
  gain_t              g_new;
  logic [3:0]         idx;

  assign idx        = sub_ff[3:0];
  assign hb_done    = addr_ff == 10'(`HES_FRAME_LEN);
  assign o_hb_ready = i_ce & (state_ff == ST_LOAD) & !hb_done;
  assign o_qmf_ready = i_ce & (state_ff == ST_LOAD) & !slot_ff[4];
  assign hb_take    = i_hb_valid & o_hb_ready;
  assign qmf_take   = i_qmf_valid & o_qmf_ready;
  assign sq = 32'($signed(i_hb_data) * $signed(i_hb_data));
  assign band_sum = bacc_ff + 40'($signed(i_qmf_re) * $signed(i_qmf_re))
                  + 40'($signed(i_qmf_im) * $signed(i_qmf_im));
  // log of the mean power = log of sum minus log of count
  assign slot_lg = sacc_ff + log2q(lin_t'(band_sum))
                 - log2q(lin_t'(bcnt_ff) + lin_t'(1));
  assign div3_p  = slot_lg * $signed(`HES_DIV3);
  assign env_new = lg_t'(div3_p >>> 16);

  always_comb
  begin
    sm_acc = '0;
    for (int j = 0; j < 6; j++)
      if (int'(idx) >= j)
        sm_acc = sm_acc + 32'(env_l[idx - 4'(j)] * $signed({1'b0, SC[j]}));
  end
  assign sm_p  = 34'(sm_acc >>> 8) * $signed(`HES_SM_SCALE);
  assign lg_hn = (mode_ff.level == 2'h1) ? env_l[idx] : lg_t'(sm_p >>> 12);
  assign lg_tot = log2q(tot_ff);
  assign lg_en  = log2q(lin_t'(enr[idx]));
  assign cand   = lg_tot - `HES_LG_16 - lg_en;

  // esum already holds the mean: each term was divided by 16 on entry
  assign lg_mean  = log2q(esum_ff) - `HES_LG_Q12;
  // floor is half of min(0.1, 1/peak), taken in the log domain; compare must be signed
  assign lg_floor = `HES_LG_HALF
                  + ((lg_t'(`HES_LG_TENTH) < -inv_ff) ? `HES_LG_TENTH : -inv_ff);
  assign lg_lim   = ((lg_h[idx] - lg_mean) < lg_floor) ? lg_floor
                  : lg_h[idx] - lg_mean;
  assign shp_lin  = exp2q(lg_lim - lg_e[idx]);
  // signed throughout, or the halving shift turns negative logs positive
  assign lg_flat  = (lg_tot - lg_t'(`HES_LG_16) - lg_e[idx]) >>> 1;
  assign flt_lin  = exp2q(lg_flat);

  always_comb
  begin
    if (mode_ff.level != 2'h0)
      g_new = (shp_lin > lin_t'(`HES_G_CAP)) ? `HES_G_CAP : shp_lin[17:0];
    else if (mode_ff.flat)
      g_new = (flt_lin > lin_t'(`HES_G_MAX)) ? `HES_G_MAX : flt_lin[17:0];
    else
      g_new = `HES_Q_ONE;
  end

  // samples scaled per subframe, saturated back to 16 bits
  assign out_p = mem[addr_ff] * $signed({1'b0, gain[idx]});
  always_comb
  begin
    if ((out_p >>> 12) > 35'sd32767)
      src.data = 16'h7fff;
    else if ((out_p >>> 12) < -35'sd32768)
      src.data = 16'h8000;
    else
      src.data = 16'(out_p >>> 12);
  end
  assign src.valid = (state_ff == ST_OUT);

  always_comb
  begin
    nxt_state = state_ff;
    {nxt_sub, nxt_pos} = {sub_ff, pos_ff};
    nxt_addr = addr_ff;
    nxt_slot = slot_ff;
    nxt_band = band_ff;
    nxt_bacc = bacc_ff;
    nxt_bcnt = bcnt_ff;
    nxt_sacc = sacc_ff;
    nxt_inv  = inv_ff;
    nxt_mode = mode_ff;
    nxt_tot  = tot_ff;
    nxt_esum = esum_ff;
    {mem_we, enr_we, env_we, h_we, g_we} = 5'h00;
    unique case (state_ff)
      ST_LOAD:
      begin
        if (hb_take)
        begin
          {mem_we, enr_we} = 2'h3;
          if (addr_ff == 10'h000)
            nxt_mode = decode(i_mode);
          nxt_tot  = ((addr_ff == 10'h000) ? '0 : tot_ff) + lin_t'(sq);
          {nxt_sub, nxt_pos} = step(sub_ff, pos_ff);
          nxt_addr = addr_ff + 10'h001;
        end
        if (qmf_take)
        begin
          nxt_bacc = i_qmf_band_end ? 40'h0 : band_sum;
          nxt_bcnt = i_qmf_band_end ? 8'h00 : bcnt_ff + 8'h01;
          if (i_qmf_band_end && band_ff == 2'h2)
          begin
            env_we   = 1'b1;
            nxt_slot = slot_ff + 5'h01;
            nxt_band = 2'h0;
            nxt_sacc = '0;
          end
          else if (i_qmf_band_end)
          begin
            nxt_band = band_ff + 2'h1;
            nxt_sacc = slot_lg;
          end
        end
        if (hb_done && slot_ff[4])
        begin
          nxt_state = ST_ENV;
          {nxt_sub, nxt_pos} = 11'h000;
          nxt_esum = '0;
          nxt_inv  = `HES_LG_MIN_INV;
        end
      end
      ST_ENV:
      begin
        h_we     = 1'b1;
        nxt_esum = esum_ff + (exp2q(lg_hn) >> 4);
        nxt_inv  = (cand > inv_ff) ? cand : inv_ff;
        nxt_sub  = sub_ff + 5'h01;
        if (sub_ff == 5'h0f)
        begin
          nxt_state = ST_GAIN;
          nxt_sub   = 5'h00;
        end
      end
      ST_GAIN:
      begin
        g_we    = 1'b1;
        nxt_sub = sub_ff + 5'h01;
        if (sub_ff == 5'h0f)
        begin
          nxt_state = ST_OUT;
          nxt_sub   = 5'h00;
          nxt_addr  = 10'h000;
        end
      end
      ST_OUT:
      begin
        if (src.ready)
        begin
          {nxt_sub, nxt_pos} = step(sub_ff, pos_ff);
          nxt_addr = addr_ff + 10'h001;
          if (addr_ff == LAST_ADDR)
          begin
            nxt_state = ST_LOAD;
            {nxt_sub, nxt_pos} = 11'h000;
            nxt_addr  = 10'h000;
            nxt_slot  = 5'h00;
            nxt_band  = 2'h0;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_ff <= ST_LOAD;
      sub_ff   <= 5'h00;
      pos_ff   <= 6'h00;
      addr_ff  <= 10'h000;
      slot_ff  <= 5'h00;
      band_ff  <= 2'h0;
      bacc_ff  <= 40'h0;
      bcnt_ff  <= 8'h00;
      sacc_ff  <= '0;
      inv_ff   <= '0;
      mode_ff  <= '0;
      tot_ff   <= '0;
      esum_ff  <= '0;
    end
    else if (i_ce)
    begin
      state_ff <= nxt_state;
      sub_ff   <= nxt_sub;
      pos_ff   <= nxt_pos;
      addr_ff  <= nxt_addr;
      slot_ff  <= nxt_slot;
      band_ff  <= nxt_band;
      bacc_ff  <= nxt_bacc;
      bcnt_ff  <= nxt_bcnt;
      sacc_ff  <= nxt_sacc;
      inv_ff   <= nxt_inv;
      mode_ff  <= nxt_mode;
      tot_ff   <= nxt_tot;
      esum_ff  <= nxt_esum;
    end
  end

  // storage arrays carry no reset; each frame overwrites what it reads
  always_ff @(posedge i_clk_sys)
  begin
    if (i_ce && mem_we)
      mem[addr_ff] <= i_hb_data;
    if (i_ce && enr_we)
      enr[idx] <= ((pos_ff == 6'h00) ? 40'h0 : enr[idx]) + 40'(sq);
    if (i_ce && env_we)
      env_l[slot_ff[3:0]] <= env_new;
    if (i_ce && h_we)
    begin
      lg_h[idx] <= lg_hn;
      lg_e[idx] <= lg_en;
    end
    if (i_ce && g_we)
      gain[idx] <= g_new;
  end

  skid_buf2 u_obuf (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_ce      (i_ce),
    .s_in      (src.snk),
    .o_valid   (o_out_valid),
    .o_data    (o_out_data),
    .i_ready   (i_out_ready)
  );

  assign o_busy        = state_ff != ST_LOAD;
  assign o_shape_level = mode_ff.level;
  assign o_flat        = mode_ff.flat;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  a_mode_decode: assert property (hb_take && addr_ff == 10'h000
    |=> mode_ff == decode($past(i_mode))) else $error("codeword decoded wrongly");
  a_mode_excl: assert property (mode_ff.level != 2'h0 |-> !mode_ff.flat)
    else $error("shaping and flattening both active");
  a_energy_sum: assert property (hb_take && pos_ff == 6'h00
    |=> enr[$past(idx)] == 40'($past(sq))) else $error("subframe energy not restarted");
  a_env_pass: assert property (state_ff == ST_ENV && sub_ff == 5'h0f && i_ce
    |=> state_ff == ST_GAIN && sub_ff == 5'h00) else $error("envelope pass length wrong");
  a_gain_cap: assert property (g_we && mode_ff.level != 2'h0
    |-> g_new <= `HES_G_CAP) else $error("shaping gain above 3.0");
  a_pass_gain: assert property (g_we && mode_ff == '0 |-> g_new == `HES_Q_ONE)
    else $error("pass-through gain not unity");
  a_pass_data: assert property (src.valid && mode_ff == '0
    |-> src.data == mem[addr_ff]) else $error("pass-through sample altered");
  a_flat_unity: assert property (g_we && mode_ff.flat && lg_flat == '0
    |-> g_new == `HES_Q_ONE) else $error("equal energy gave non-unity flat gain");
  a_sub_wrap: assert property (src.valid && src.ready && i_ce && pos_ff == LAST_POS
    |=> pos_ff == 6'h00
        && sub_ff == (($past(addr_ff) == LAST_ADDR) ? 5'h00 : $past(sub_ff) + 5'h01))
    else $error("subframe boundary missed");
  a_frame_end: assert property (src.valid && src.ready && i_ce && addr_ff == LAST_ADDR
    |=> state_ff == ST_LOAD && addr_ff == 10'h000) else $error("frame did not end");

  c_shape2: cover property (src.valid && src.ready && addr_ff == LAST_ADDR
    && mode_ff.level == 2'h2);
  c_flat: cover property (src.valid && src.ready && addr_ff == LAST_ADDR && mode_ff.flat);
  c_stall: cover property (o_out_valid && !i_out_ready ##1 !src.ready);
endmodule
`default_nettype wire

// *** verif/hes_upstream.sv ***
// upstream model: feeds one frame of highband samples and low-band qmf beats
// assumes the shaper's ready outputs are sampled at the rising edge
`default_nettype none
module hes_upstream
  import hes_pkg::*;
(
  input  wire logic        i_clk_sys,
  input  wire logic        i_hb_ready,
  input  wire logic        i_qmf_ready,
  output logic [1:0]       o_mode,
  output logic             o_hb_valid,
  output logic [15:0]      o_hb_data,
  output logic             o_qmf_valid,
  output logic [15:0]      o_qmf_re,
  output logic [15:0]      o_qmf_im,
  output logic             o_qmf_band_end
);
  timeunit 1ns;
  timeprecision 1ps;

  int timeouts = 0;

  initial
  begin
    o_mode = 2'h0;
    o_hb_valid = 1'b0;
    o_hb_data = 16'h0000;
    o_qmf_valid = 1'b0;
    o_qmf_re = 16'h0000;
    o_qmf_im = 16'h0000;
    o_qmf_band_end = 1'b0;
  end

  // pattern 0: slow ramp; pattern 1: subframes alternate 1000 and 200, sign flips
  function automatic logic [15:0] hb_sample(input int n, input int pat);
    int a;
    a = (pat == 0) ? (n * 37 - 11000) : ((((n / 40) % 2) == 1) ? 200 : 1000);
    if (pat != 0 && (n % 2) == 1)
      a = -a;
    return a[15:0];
  endfunction

  task automatic send_hb(input logic [1:0] mode, input int pat);
    int n;
    int t;
    for (n = 0; n < 640; n++)
    begin
      o_hb_valid <= 1'b1;
      o_hb_data <= hb_sample(n, pat);
      o_mode <= mode;
      t = 0;
      do
      begin
        @(posedge i_clk_sys);
        t++;
      end while (i_hb_ready !== 1'b1 && t < 2000);
      // a stuck handshake gives up the frame; the bench counts it
      if (i_hb_ready !== 1'b1)
      begin
        timeouts++;
        return;
      end
    end
    // released lines show a changed value, never a stale one
    o_hb_valid <= 1'b0;
    o_hb_data <= ~o_hb_data;
    o_mode <= ~mode;
  endtask

  // 16 slots, bands 0..2 each, two coefficients per band
  task automatic send_qmf();
    int b;
    int c;
    int t;
    for (b = 0; b < 48; b++)
    begin
      for (c = 0; c < 2; c++)
      begin
        o_qmf_valid <= 1'b1;
        o_qmf_re <= 16'(1000 + (b / 3) * 64);
        o_qmf_im <= 16'((b % 3) * 100);
        o_qmf_band_end <= (c == 1);
        t = 0;
        do
        begin
          @(posedge i_clk_sys);
          t++;
        end while (i_qmf_ready !== 1'b1 && t < 2000);
        if (i_qmf_ready !== 1'b1)
        begin
          timeouts++;
          return;
        end
      end
    end
    o_qmf_valid <= 1'b0;
    o_qmf_re <= ~o_qmf_re;
    o_qmf_im <= ~o_qmf_im;
    o_qmf_band_end <= 1'b0;
  endtask

  task automatic send_frame(input logic [1:0] mode, input int pat);
    fork
      send_hb(mode, pat);
      send_qmf();
    join
  endtask
endmodule
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the highband envelope shaper, one frame per scenario
// assumes the upstream model in hes_upstream and a 40 MHz system clock
`default_nettype none
module testbench;
  import hes_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic        i_clk_sys;
  logic        i_rst_n;
  logic        i_ce = 1'b1;
  logic [1:0]  mode;
  logic        hb_valid;
  logic [15:0] hb_data;
  logic        hb_ready;
  logic        qmf_valid;
  logic [15:0] qmf_re;
  logic [15:0] qmf_im;
  logic        qmf_band_end;
  logic        qmf_ready;
  logic        o_out_valid;
  logic [15:0] o_out_data;
  logic        i_out_ready = 1'b1;
  logic        o_busy;
  logic [1:0]  o_shape_level;
  logic        o_flat;
  logic        stall_en;
  int          cyc = 0;
  int          bad_count;
  int          cmp_count;
  smp_t        got[$];

  highband_envelope_shaper highband_envelope_shaper_inst (
    .i_clk_sys      (i_clk_sys),
    .i_rst_n        (i_rst_n),
    .i_ce           (i_ce),
    .i_mode         (mode),
    .i_hb_valid     (hb_valid),
    .i_hb_data      (hb_data),
    .o_hb_ready     (hb_ready),
    .i_qmf_valid    (qmf_valid),
    .i_qmf_re       (qmf_re),
    .i_qmf_im       (qmf_im),
    .i_qmf_band_end (qmf_band_end),
    .o_qmf_ready    (qmf_ready),
    .o_out_valid    (o_out_valid),
    .o_out_data     (o_out_data),
    .i_out_ready    (i_out_ready),
    .o_busy         (o_busy),
    .o_shape_level  (o_shape_level),
    .o_flat         (o_flat)
  );

  hes_upstream upstream_inst (
    .i_clk_sys      (i_clk_sys),
    .i_hb_ready     (hb_ready),
    .i_qmf_ready    (qmf_ready),
    .o_mode         (mode),
    .o_hb_valid     (hb_valid),
    .o_hb_data      (hb_data),
    .o_qmf_valid    (qmf_valid),
    .o_qmf_re       (qmf_re),
    .o_qmf_im       (qmf_im),
    .o_qmf_band_end (qmf_band_end)
  );

  initial
  begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // output sink: every third cycle stalls when asked, to fill the buffer;
  // clock enable then also drops one cycle in seven to prove the freeze
  always @(posedge i_clk_sys)
  begin
    cyc <= cyc + 1;
    if (o_out_valid === 1'b1 && i_out_ready === 1'b1)
      got.push_back(o_out_data);
    i_out_ready <= !stall_en || ((cyc % 3) != 0);
    i_ce        <= !stall_en || ((cyc % 7) != 3);
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // sends one frame, collects 640 outputs, checks the decoded mode
  task automatic run_frame(input logic [1:0] m, input int pat);
    int t;
    int busy_cyc;
    got.delete();
    busy_cyc = 0;
    @(posedge i_clk_sys);
    upstream_inst.send_frame(m, pat);
    t = 0;
    while (got.size() < 640 && t < 20000)
    begin
      @(posedge i_clk_sys);
      t++;
      if (o_busy === 1'b1)
        busy_cyc++;
    end
    if (t >= 20000)
    begin
      bad_count++;
      stop_test();
    end
    else
    begin
      check("frame length", got.size(), 640);
      check("upstream wait", upstream_inst.timeouts, 0);
      // 16 envelope, 16 gain and at least 640 output cycles
      check("busy span", (busy_cyc >= 672), 1);
      check("busy at end", o_busy, 0);
      check("shape level", o_shape_level, (m == 2'h2) ? 1 : (m == 2'h3) ? 2 : 0);
      check("flat flag", o_flat, (m == 2'h1));
    end
  endtask

  task automatic test_pass();
    int n;
    stall_en = 1'b1;
    run_frame(2'h0, 0);
    for (n = 0; n < got.size(); n++)
      check("pass sample", got[n], $signed(upstream_inst.hb_sample(n, 0)));
    stall_en = 1'b0;
  endtask

  // 1000/200 subframes flatten to about 721; 200 needs a gain above 3
  task automatic test_flat();
    int sf;
    int y;
    run_frame(2'h1, 1);
    for (sf = 0; sf < 16 && got.size() == 640; sf++)
    begin
      y = got[sf * 40];
      check("flat level", (y >= 663 && y <= 779), 1);
    end
  endtask

  task automatic test_shape(input logic [1:0] m);
    int n;
    int x;
    int y;
    run_frame(m, 0);
    for (n = 0; n < got.size(); n++)
    begin
      x = $signed(upstream_inst.hb_sample(n, 0));
      y = got[n];
      if (x < 0)
        x = -x;
      if (y < 0)
        y = -y;
      check("shape cap", (y <= 3 * x + 1), 1);
    end
  endtask

  initial
  begin
    i_rst_n = 1'b0;
    stall_en = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    check("busy after reset", o_busy, 0);
    test_pass();
    test_flat();
    test_shape(2'h2);
    test_shape(2'h3);
    stop_test();
  end
endmodule
`default_nettype wire
